// ===== hdl/supervisor_reset_watchdog.sv
// What this block does
// - power lost: pull supervisor reset low
// - power good: reset held until delay expires
// - reset delay is a software setting
// - enable pin switches watchdog on or off
// - mode pin picks timeout or window supervision
// - timeout mode: any kick edge restarts timer
// - window mode: falls between lower and upper
// - fault holds low for the reset delay
// - fault released on expiry or supervisor reset
// - both limits come from one period setting
// - mode pin low means window mode
// - disabled watchdog keeps fault output high
// - kicks ignored while fault output is low
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module supervisor_reset_watchdog
    import supervisor_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // analog comparator and processor pins
    input  wire logic        power_good_in,
    input  wire logic        kick_input_in,
    input  wire logic        kick_monitor_enable_in,
    input  wire logic        timeout_mode_in,
    // supervisor outputs
    output var  logic        supv_reset_n_out,
    output var  logic        kick_fault_n_out,
    output var  logic        irq_out,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // state of the whole block
    // ------------------------------------------------------------
    typedef struct packed {
        logic                reset_n;
        logic [31:0]         por_count;
        wd_state_t           wd_state;
        logic [31:0]         wd_count;
        logic                fault_n;
        logic [31:0]         reset_delay;
        logic [31:0]         kick_period_setting;
        logic [EV_COUNT-1:0] status;
        logic [EV_COUNT-1:0] mask;
        logic                irq;
        logic                aw_held;
        logic [7:0]          aw_addr;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } state_t;

    state_t state;
    state_t next_state;

    pin_t power_good;
    pin_t kick_input;
    pin_t kick_monitor_enable;
    pin_t timeout_mode;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(.INIT(1'b0)) u_sync_power (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (power_good_in),
        .pin_out    (power_good)
    );

    pin_sync #(.INIT(1'b0)) u_sync_kick (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (kick_input_in),
        .pin_out    (kick_input)
    );

    pin_sync #(.INIT(1'b0)) u_sync_enable (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (kick_monitor_enable_in),
        .pin_out    (kick_monitor_enable)
    );

    pin_sync #(.INIT(1'b1)) u_sync_mode (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (timeout_mode_in),
        .pin_out    (timeout_mode)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [31:0]         lower_limit;
    logic [EV_COUNT-1:0] events;
    logic                do_write;
    logic                write_hit;
    logic [31:0]         wmask;
    logic [31:0]         live;
    logic                mode_change;

    always_comb begin
        next_state  = state;
        events      = '0;
        lower_limit = state.kick_period_setting >> LOWER_SHIFT;
        mode_change = timeout_mode.rise | timeout_mode.fall;
        wmask       = {{8{state.w_strb[3]}}, {8{state.w_strb[2]}},
                       {8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
        live        = '0;
        live[LS_POWER_GOOD] = power_good.level;
        live[LS_KICK_LEVEL] = kick_input.level;
        live[LS_ENABLE]     = kick_monitor_enable.level;
        live[LS_TIMEOUT]    = timeout_mode.level;
        live[LS_RESET_N]    = state.reset_n;
        live[LS_FAULT_N]    = state.fault_n;

        // power-on reset timer
        if (!power_good.level) begin
            next_state.reset_n   = 1'b0;
            next_state.por_count = '0;
            if (state.reset_n) begin
                events[EV_SUPV_RESET] = 1'b1;
            end
        end else if (!state.reset_n) begin
            // the delay is read live, so a rewrite takes effect at once
            if (state.por_count + 32'h0000_0001 >= state.reset_delay) begin
                next_state.reset_n = 1'b1;
            end else begin
                next_state.por_count = state.por_count + 32'h0000_0001;
            end
        end

        // watchdog
        case (state.wd_state)
            WD_IDLE: begin
                next_state.fault_n  = 1'b1;
                next_state.wd_count = '0;
                if (kick_monitor_enable.level && state.reset_n) begin
                    next_state.wd_state = WD_WATCH;
                end
            end
            WD_WATCH: begin
                next_state.wd_count = state.wd_count + 32'h0000_0001;
                if (mode_change) begin
                    next_state.wd_count = '0;
                end else if (timeout_mode.level) begin
                    if (kick_input.rise || kick_input.fall) begin
                        next_state.wd_count = '0;
                    end else if (state.wd_count + 32'h0000_0001 >= state.kick_period_setting) begin
                        events[EV_KICK_LATE] = 1'b1;
                    end
                end else begin
                    if (kick_input.fall) begin
                        if (state.wd_count < lower_limit) begin
                            events[EV_KICK_EARLY] = 1'b1;
                        end else begin
                            next_state.wd_count = '0;
                        end
                    end else if (state.wd_count + 32'h0000_0001 >= state.kick_period_setting) begin
                        events[EV_KICK_LATE] = 1'b1;
                    end
                end
                if (events[EV_KICK_LATE] || events[EV_KICK_EARLY]) begin
                    next_state.wd_state = WD_FAULT;
                    next_state.fault_n  = 1'b0;
                    next_state.wd_count = '0;
                end
            end
            WD_FAULT: begin
                // kick edges are not looked at here
                next_state.wd_count = state.wd_count + 32'h0000_0001;
                if (state.wd_count + 32'h0000_0001 >= state.reset_delay) begin
                    next_state.wd_state = WD_WATCH;
                    next_state.fault_n  = 1'b1;
                    next_state.wd_count = '0;
                end
            end
            default: begin
                next_state.wd_state = WD_IDLE;
            end
        endcase

        // supervisor reset and disable override the watchdog state above
        if (!power_good.level || !state.reset_n) begin
            next_state.wd_state = WD_IDLE;
            next_state.fault_n  = 1'b1;
            next_state.wd_count = '0;
        end
        if (!kick_monitor_enable.level) begin
            next_state.wd_state = WD_IDLE;
            next_state.fault_n  = 1'b1;
            next_state.wd_count = '0;
        end
        if (!power_good.level || !kick_monitor_enable.level) begin
            events[EV_KICK_LATE]  = 1'b0;
            events[EV_KICK_EARLY] = 1'b0;
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        do_write  = state.aw_held && state.w_held && !state.bvalid;
        write_hit = 1'b0;
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            write_hit          = 1'b1;
            case (state.aw_addr)
                REG_RESET_DELAY: begin
                    next_state.reset_delay = (state.reset_delay & ~wmask)
                                           | (state.w_data & wmask);
                end
                REG_KICK_PERIOD: begin
                    next_state.kick_period_setting = (state.kick_period_setting & ~wmask)
                                                   | (state.w_data & wmask);
                end
                REG_EVENT_STATUS: begin
                    if (state.w_strb[0]) begin
                        next_state.status = state.status & ~state.w_data[EV_COUNT-1:0];
                    end
                end
                REG_EVENT_MASK: begin
                    if (state.w_strb[0]) begin
                        next_state.mask = state.w_data[EV_COUNT-1:0];
                    end
                end
                REG_LIVE_STATE: begin
                end
                default: begin
                    write_hit = 1'b0;
                end
            endcase
            next_state.bresp = write_hit ? RESP_OKAY : RESP_DECERR;
        end
        // a new event wins over a clear in the same cycle
        next_state.status  = next_state.status | events;
        next_state.irq     = |(next_state.status & next_state.mask);
        next_state.awready = !next_state.aw_held;
        next_state.wready  = !next_state.w_held;

        // read channel: one read under way, answer the cycle after
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end
        if (s_axi_arvalid && state.arready) begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            next_state.rresp   = RESP_OKAY;
            case (s_axi_araddr)
                REG_RESET_DELAY:  next_state.rdata = state.reset_delay;
                REG_KICK_PERIOD:  next_state.rdata = state.kick_period_setting;
                REG_EVENT_STATUS: next_state.rdata = {{(32-EV_COUNT){1'b0}}, state.status};
                REG_EVENT_MASK:   next_state.rdata = {{(32-EV_COUNT){1'b0}}, state.mask};
                REG_LIVE_STATE:   next_state.rdata = live;
                default: begin
                    next_state.rdata = '0;
                    next_state.rresp = RESP_DECERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state                     <= '0;
            state.wd_state            <= WD_IDLE;
            state.fault_n             <= 1'b1;
            state.reset_delay         <= RESET_DELAY_INIT;
            state.kick_period_setting <= KICK_PERIOD_INIT;
            state.mask                <= EVENT_MASK_INIT;
            state.awready             <= 1'b1;
            state.wready              <= 1'b1;
            state.arready             <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    always_comb begin
        supv_reset_n_out = state.reset_n;
        kick_fault_n_out = state.fault_n;
        irq_out          = state.irq;
        s_axi_awready    = state.awready;
        s_axi_wready     = state.wready;
        s_axi_bvalid     = state.bvalid;
        s_axi_bresp      = state.bresp;
        s_axi_arready    = state.arready;
        s_axi_rvalid     = state.rvalid;
        s_axi_rdata      = state.rdata;
        s_axi_rresp      = state.rresp;
    end

endmodule

`default_nettype wire

// ===== hdl/supervisor_pkg.sv
`default_nettype none

package supervisor_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET_DELAY   = 8'h00;
    localparam logic [7:0] REG_KICK_PERIOD   = 8'h04;
    localparam logic [7:0] REG_EVENT_STATUS  = 8'h08;
    localparam logic [7:0] REG_EVENT_MASK    = 8'h0C;
    localparam logic [7:0] REG_LIVE_STATE    = 8'h10;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_DELAY_INIT = 32'h0000_1000;
    localparam logic [31:0] KICK_PERIOD_INIT = 32'h0001_0000;
    localparam logic [2:0]  EVENT_MASK_INIT  = 3'h0;

    // window lower limit is the period setting shifted right by this
    localparam int unsigned LOWER_SHIFT = 5;

    // ------------------------------------------------------------
    // event status bit positions
    // ------------------------------------------------------------
    localparam int unsigned EV_SUPV_RESET = 0;
    localparam int unsigned EV_KICK_LATE  = 1;
    localparam int unsigned EV_KICK_EARLY = 2;
    localparam int unsigned EV_COUNT      = 3;

    // ------------------------------------------------------------
    // live state bit positions
    // ------------------------------------------------------------
    localparam int unsigned LS_POWER_GOOD = 0;
    localparam int unsigned LS_KICK_LEVEL = 1;
    localparam int unsigned LS_ENABLE     = 2;
    localparam int unsigned LS_TIMEOUT    = 3;
    localparam int unsigned LS_RESET_N    = 4;
    localparam int unsigned LS_FAULT_N    = 5;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_WATCH,
        WD_FAULT
    } wd_state_t;

    // synchronised pin with its edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } pin_t;

endpackage

`default_nettype wire

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync
    import supervisor_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    // pin and its synchronised view
    input  wire logic pin_in,
    output var  pin_t pin_out
);

    logic meta;
    logic stable;
    logic last;

    // meta feeds only stable; edges compare stable with last
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta   <= INIT;
            stable <= INIT;
            last   <= INIT;
        end else begin
            meta   <= pin_in;
            stable <= meta;
            last   <= stable;
        end
    end

    always_comb begin
        pin_out.level = stable;
        pin_out.rise  = stable & ~last;
        pin_out.fall  = ~stable & last;
    end

endmodule

`default_nettype wire

// ===== tb/supervisor_properties.sv
`timescale 1ns/100ps
`default_nettype none

module supervisor_properties (
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        reset_in,
    // pins
    input wire logic        power_good_in,
    input wire logic        kick_monitor_enable_in,
    input wire logic        supv_reset_n_out,
    input wire logic        kick_fault_n_out,
    // bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // --------
    // steps
    // --------
    // four raw cycles cover the two-stage synchroniser and the reset_n register
    sequence power_lost_s;
        !power_good_in [*4];
    endsequence
    sequence write_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    pg_loss_reset_a:
        assert property (power_lost_s |-> ##[0:2] !supv_reset_n_out) else $error("reset not pulled");
    reset_release_a:
        assert property ($rose(supv_reset_n_out) |-> $past(power_good_in, 3)) else $error("early release");
    disabled_high_a:
        assert property (!kick_monitor_enable_in [*5] |-> kick_fault_n_out) else $error("fault while off");
    reset_frees_fault_a:
        assert property (!supv_reset_n_out |-> kick_fault_n_out) else $error("fault kept");
    fault_needs_enable_a:
        assert property ($fell(kick_fault_n_out) |-> $past(kick_monitor_enable_in, 3)) else $error("fault off");
    rd_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    rd_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read dropped");
    wr_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("response dropped");
    wr_answer_a:
        assert property (write_taken_s |-> ##2 s_axi_bvalid) else $error("write late");
endmodule

bind supervisor_reset_watchdog supervisor_properties chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .power_good_in(power_good_in),
    .kick_monitor_enable_in(kick_monitor_enable_in), .supv_reset_n_out(supv_reset_n_out),
    .kick_fault_n_out(kick_fault_n_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ===== tb/kick_host.sv
`timescale 1ns/100ps
`default_nettype none

module kick_host (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // control from the bench
    input  wire logic        run_in,
    input  wire logic [15:0] half_in,
    // kick line
    output var  logic        kick_out
);
    logic [15:0] count;

    // toggles every half_in+1 cycles; stopping freezes the level, as a hung processor would
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            count    <= 16'h0000;
            kick_out <= 1'b1;
        end else if (run_in) begin
            if (count >= half_in) begin
                count    <= 16'h0000;
                kick_out <= !kick_out;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/supervisor_reset_watchdog_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module supervisor_reset_watchdog_tb_top import supervisor_pkg::*;;
    logic        clk, rst, pg, en, mode, run, kick, rst_n, fault_n, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rnd;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] half;
    logic [33:0] expect_q[$];
    int          n_errors, samples_checked, n;

    supervisor_reset_watchdog dut (.sys_clk_in(clk), .reset_in(rst), .power_good_in(pg),
        .kick_input_in(kick), .kick_monitor_enable_in(en), .timeout_mode_in(mode),
        .supv_reset_n_out(rst_n), .kick_fault_n_out(fault_n), .irq_out(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    kick_host host (.sys_clk_in(clk), .reset_in(rst), .run_in(run), .half_in(half), .kick_out(kick));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // --------
    // bus cycles
    // --------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 100 && !(bvalid && bready); i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (i == 100) check("write wait", 1'b0, 1'b1);
        check("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, r});
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        int i;
        expect_q.push_back(exp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 100 && !(rvalid && rready); i++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (i == 100) check("read wait", 1'b0, 1'b1);
        @(posedge clk);
    endtask

    // counts edges until the watched output reaches lvl, giving up after lim
    task automatic wait_lvl(input logic fault, input logic lvl, input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if ((fault ? fault_n : rst_n) === lvl) break;
        end
    endtask

    always @(posedge clk) begin
        if (rvalid && rready) check("read", {rresp, rdata}, expect_q.pop_front());
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {rst, pg, en, mode, run} = 5'h11;
        half = 16'h000A;
        rnd  = 32'h0000_AC70;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("out", {rst_n, fault_n, irq}, 3'b010);
        rd(REG_RESET_DELAY, {RESP_OKAY, RESET_DELAY_INIT});
        rd(REG_KICK_PERIOD, {RESP_OKAY, KICK_PERIOD_INIT});
        rd(8'h14, {RESP_DECERR, 32'h0000_0000});
        wr(8'h14, 32'h0000_0001, RESP_DECERR);
        rnd = xorshift(rnd);
        wr(REG_RESET_DELAY, {16'h0000, rnd[15:0]}, RESP_OKAY);
        rd(REG_RESET_DELAY, {RESP_OKAY, 16'h0000, rnd[15:0]});
        wr(REG_RESET_DELAY, 32'h0000_0008, RESP_OKAY);
        wr(REG_KICK_PERIOD, 32'h0000_0100, RESP_OKAY);
        pg <= 1'b1;
        wait_lvl(1'b0, 1'b1, 40);
        check("release", n >= 8 && n <= 13, 1'b1);
        wr(REG_EVENT_STATUS, 32'h0000_0007, RESP_OKAY);
        wr(REG_EVENT_MASK, 32'h0000_0007, RESP_OKAY);
        // timeout mode with randomly paced kicks
        {en, mode, run} <= 3'b111;
        rnd = xorshift(rnd);
        half <= 16'h000A + {11'h000, rnd[4:0]};
        wait_lvl(1'b1, 1'b0, 600);
        check("no fault", n, 600);
        run <= 1'b0;
        wait_lvl(1'b1, 1'b0, 300);
        check("late", n >= 200 && n <= 262, 1'b1);
        run <= 1'b1;
        wait_lvl(1'b1, 1'b1, 40);
        check("hold", n >= 7 && n <= 9, 1'b1);
        check("irq", irq, 1'b1);
        rd(REG_EVENT_STATUS, {RESP_OKAY, 32'h0000_0002});
        wr(REG_EVENT_MASK, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge clk);
        check("irq masked", irq, 1'b0);
        wr(REG_EVENT_MASK, 32'h0000_0007, RESP_OKAY);
        wr(REG_EVENT_STATUS, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge clk);
        check("irq clear", irq, 1'b0);
        // window mode: falls every 82 cycles sit between 8 and 256
        // switch right after a kick fall, so the first window is a full one
        for (n = 0; n < 100 && kick !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 100 && kick !== 1'b0; n++) @(posedge clk);
        if (n == 100) check("kick wait", 1'b0, 1'b1);
        {mode, half} <= {1'b0, 16'h0028};
        wait_lvl(1'b1, 1'b0, 500);
        check("window ok", n, 500);
        half <= 16'h0001;
        wait_lvl(1'b1, 1'b0, 40);
        check("early", n < 40, 1'b1);
        rd(REG_EVENT_STATUS, {RESP_OKAY, 32'h0000_0004});
        run <= 1'b0;
        wr(REG_RESET_DELAY, 32'h0000_0040, RESP_OKAY);
        // the delay is read live, so the fault under way stretches to 64 cycles
        wait_lvl(1'b1, 1'b1, 100);
        wait_lvl(1'b1, 1'b0, 300);
        check("window late", n >= 240 && n < 300, 1'b1);
        pg <= 1'b0;
        wait_lvl(1'b0, 1'b0, 10);
        check("power loss", n < 6, 1'b1);
        @(posedge clk);
        check("fault freed", fault_n, 1'b1);
        {pg, en} <= 2'b10;
        wait_lvl(1'b0, 1'b1, 100);
        wait_lvl(1'b1, 1'b0, 400);
        check("disabled", n, 400);
        rd(REG_LIVE_STATE, {RESP_OKAY, 26'h000_0000, 4'hC, kick, 1'b1});
        wrap_up();
    end
endmodule
`default_nettype wire
